/* File: core/ubd_pkg.sv */
// Shared constants and types of the USB buffer descriptor table block.
// Assumes a 32-bit AXI4-Lite register port and a 12-bit byte address.
package ubd_pkg;

  // Register byte offsets
  localparam logic [11:0] UBD_CFG_OFS = 12'h000;
  localparam logic [11:0] UBD_XSTAT_OFS = 12'h004;
  localparam logic [11:0] UBD_SFLAG_OFS = 12'h008;
  localparam logic [11:0] UBD_SEN_OFS = 12'h00c;
  localparam logic [11:0] UBD_EFLAG_OFS = 12'h010;
  localparam logic [11:0] UBD_EEN_OFS = 12'h014;
  // Descriptor table window, one word per descriptor
  localparam logic [11:0] UBD_TABLE_BASE = 12'h400;
  localparam logic [3:0] UBD_TABLE_PAGE = 4'h4;
  localparam int UBD_NUM_DESC = 64;
  localparam int UBD_NUM_EP = 16;

  // Configuration register fields
  localparam int UBD_CFG_MODE_LSB = 0;
  localparam int UBD_CFG_PTRRST_BIT = 2;
  localparam int UBD_CFG_ENABLE_BIT = 3;
  localparam logic [1:0] UBD_MODE_NONE = 2'b00;
  localparam logic [1:0] UBD_MODE_EP0OUT = 2'b01;
  localparam logic [1:0] UBD_MODE_ALL = 2'b10;

  // Descriptor status byte fields
  localparam int UBD_ST_OWN_BIT = 7;
  localparam int UBD_ST_TOGGLE_BIT = 6;
  localparam int UBD_ST_KEEP_BIT = 5;
  localparam int UBD_ST_TCHK_BIT = 3;
  localparam int UBD_ST_STALL_BIT = 2;

  // Status interrupt flag positions
  localparam int UBD_SF_SOF = 6;
  localparam int UBD_SF_STALL = 5;
  localparam int UBD_SF_IDLE = 4;
  localparam int UBD_SF_TRN = 3;
  localparam int UBD_SF_ACTV = 2;
  localparam int UBD_SF_ERR = 1;
  localparam int UBD_SF_BUSRST = 0;
  localparam logic [7:0] UBD_SF_WMASK = 8'h7d;

  // Reset values
  localparam logic [7:0] UBD_FLAG_RST = 8'h00;
  localparam logic [31:0] UBD_PTR_RST = 32'h0000_0000;

  // Handshake codes towards the engine
  localparam logic [1:0] UBD_RSP_ACK = 2'h0;
  localparam logic [1:0] UBD_RSP_NAK = 2'h1;
  localparam logic [1:0] UBD_RSP_STALL = 2'h2;

  // AXI responses
  localparam logic [1:0] UBD_AXI_OKAY = 2'h0;
  localparam logic [1:0] UBD_AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    UBD_IDLE = 3'b001,
    UBD_LOOK = 3'b010,
    UBD_EVAL = 3'b100
  } ubd_fsm_t;

  typedef struct packed {
    logic awPend;
    logic [11:0] awAddr;
    logic wPend;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [1:0] mode;
    logic ptrRst;
    logic enable;
    logic enPrev;
    logic [31:0] ptr;
    logic [3:0] xEp;
    logic xDir;
    logic xOdd;
    logic [7:0] sFlag;
    logic [7:0] sEn;
    logic [7:0] eFlag;
    logic [7:0] eEn;
    ubd_fsm_t fsm;
    logic [3:0] cEp;
    logic cDir;
    logic [3:0] cPid;
    logic [9:0] cCnt;
    logic cTog;
    logic cSetup;
    logic cErr;
    logic [5:0] idx;
    logic odd;
    logic [31:0] desc;
    logic rspValid;
    logic [1:0] rspCode;
    logic [15:0] rspAddr;
    logic [5:0] rspIdx;
  } ubd_state_t;

endpackage

/* File: core/ubd_table.sv */
// Buffer descriptor table, ping-pong pointers and interrupt funnel.
// Assumes one AXI4-Lite master and one serial engine request at a time.
`timescale 1ns/10ps
`default_nettype none

module ubd_table (
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial engine transaction request
  input wire logic txnValid,
  output logic txnReady,
  input wire logic [3:0] txnEp,
  input wire logic txnDir,
  input wire logic [3:0] txnPid,
  input wire logic [9:0] txnCount,
  input wire logic txnToggle,
  input wire logic txnSetup,
  input wire logic txnError,
  // Engine answer
  output logic rspValid,
  output logic [1:0] rspCode,
  output logic [15:0] rspBufAddr,
  output logic [5:0] rspIndex,
  // Bus events from the engine
  input wire logic evtSof,
  input wire logic evtIdle,
  input wire logic evtActivity,
  input wire logic evtBusReset,
  input wire logic [7:0] errEvents,
  output logic usbIrqRequest
);
  import ubd_pkg::*;

  ubd_state_t cur_r;
  ubd_state_t cur_nxt;

  // Descriptor storage; no reset so contents stay unknown
  logic [31:0] descMem [UBD_NUM_DESC];
  logic memWe;
  logic [5:0] memAddr;
  logic [31:0] memData;
  logic [3:0] memStrb;

  // Decision signals of the evaluation step
  logic [7:0] st;
  logic owned;
  logic [9:0] maxCnt;
  logic evAck;
  logic evWb;
  logic evRelease;
  logic evStall;
  logic evTrn;
  logic [1:0] evCode;
  logic [7:0] wbStatus;
  logic errSummary;
  logic [7:0] sFlagView;

  // Descriptor window hit
  function automatic logic isDesc(input logic [11:0] a);
    isDesc = (a[11:8] == UBD_TABLE_PAGE);
  endfunction

  // Index of the descriptor for an endpoint, direction and pointer
  function automatic logic [5:0] descIndex(input logic [1:0] m, input logic [3:0] ep,
                                           input logic dir, input logic odd);
    logic [5:0] e;
    e = {2'b00, ep};
    descIndex = {e[4:0], dir};
    if (m == UBD_MODE_ALL) begin
      descIndex = {ep, dir, odd};
    end else if (m == UBD_MODE_EP0OUT) begin
      if (ep == 4'h0) begin
        descIndex = dir ? 6'h02 : {5'h00, odd};
      end else begin
        descIndex = {e[4:0], 1'b0} + {5'h00, 1'b1} + {5'h00, dir};
      end
    end
  endfunction

  // Whether the pointer of an endpoint and direction alternates in a mode
  function automatic logic usesPingPong(input logic [1:0] m, input logic [3:0] ep,
                                        input logic dir);
    usesPingPong = (m == UBD_MODE_ALL) ||
                   ((m == UBD_MODE_EP0OUT) && (ep == 4'h0) && !dir);
  endfunction

  // Register read mux
  function automatic logic [31:0] regRead(input ubd_state_t s, input logic [11:0] a,
                                          input logic [7:0] sfv);
    regRead = 32'h0000_0000;
    if (a == UBD_CFG_OFS) begin
      regRead = {28'h0000000, s.enable, s.ptrRst, s.mode};
    end else if (a == UBD_XSTAT_OFS) begin
      regRead = {25'h0000000, s.xEp, s.xDir, s.xOdd, 1'b0};
    end else if (a == UBD_SFLAG_OFS) begin
      regRead = {24'h000000, sfv};
    end else if (a == UBD_SEN_OFS) begin
      regRead = {24'h000000, s.sEn};
    end else if (a == UBD_EFLAG_OFS) begin
      regRead = {24'h000000, s.eFlag};
    end else if (a == UBD_EEN_OFS) begin
      regRead = {24'h000000, s.eEn};
    end
  endfunction

  function automatic logic regHit(input logic [11:0] a);
    regHit = (a == UBD_CFG_OFS) || (a == UBD_XSTAT_OFS) || (a == UBD_SFLAG_OFS) ||
             (a == UBD_SEN_OFS) || (a == UBD_EFLAG_OFS) || (a == UBD_EEN_OFS);
  endfunction

  // Evaluate the captured descriptor against the transaction
  always_comb begin
    st = cur_r.desc[7:0];
    owned = st[UBD_ST_OWN_BIT];
    maxCnt = {st[1:0], cur_r.desc[15:8]};
    evAck = 1'b0;
    evWb = 1'b0;
    evStall = 1'b0;
    evCode = UBD_RSP_NAK;
    if (!owned) begin
      evCode = UBD_RSP_NAK;
    end else if (st[UBD_ST_STALL_BIT] && !cur_r.cSetup) begin
      evCode = UBD_RSP_STALL;
      evStall = 1'b1;
    end else if (cur_r.cErr) begin
      evCode = UBD_RSP_NAK;
    end else if (!cur_r.cDir && (cur_r.cCnt > maxCnt)) begin
      // Oversized OUT packet is refused and the count left alone
      evCode = UBD_RSP_NAK;
    end else if (st[UBD_ST_TCHK_BIT] && !cur_r.cSetup &&
                 (cur_r.cTog != st[UBD_ST_TOGGLE_BIT])) begin
      // Wrong toggle: acknowledged but dropped, descriptor untouched
      evCode = UBD_RSP_ACK;
    end else begin
      evCode = UBD_RSP_ACK;
      evAck = 1'b1;
      evWb = 1'b1;
    end
    // Keep option holds ownership; a setup through a stall releases it
    evRelease = evAck && !(st[UBD_ST_KEEP_BIT] && !st[UBD_ST_STALL_BIT]);
    evTrn = evAck;
    // Bit 6 kept, token id and count upper bits replaced
    wbStatus = {!evRelease, st[UBD_ST_TOGGLE_BIT], cur_r.cPid, cur_r.cCnt[9:8]};
  end

  // Error summary and status flag view
  always_comb begin
    errSummary = |(cur_r.eFlag & cur_r.eEn);
    sFlagView = cur_r.sFlag & UBD_SF_WMASK;
    sFlagView[UBD_SF_ERR] = errSummary;
  end

  // Next-state logic
  always_comb begin
    logic doWrite;
    logic axiMemWr;
    logic [31:0] ptrNext;
    logic [7:0] sSet;
    logic [5:0] pBit;
    doWrite = 1'b0;
    axiMemWr = 1'b0;
    ptrNext = cur_r.ptr;
    sSet = 8'h00;
    pBit = {1'b0, cur_r.cEp, cur_r.cDir};
    cur_nxt = cur_r;
    memWe = 1'b0;
    memAddr = cur_r.idx;
    memData = 32'h0000_0000;
    memStrb = 4'h0;
    cur_nxt.rspValid = 1'b0;

    // AXI write address and data, taken in either order
    if (s_axi_awvalid && !cur_r.awPend) begin
      cur_nxt.awPend = 1'b1;
      cur_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur_r.wPend) begin
      cur_nxt.wPend = 1'b1;
      cur_nxt.wData = s_axi_wdata;
      cur_nxt.wStrb = s_axi_wstrb;
    end
    if (cur_r.bValid && s_axi_bready) begin
      cur_nxt.bValid = 1'b0;
    end

    // Engine write-back owns the RAM port in its cycle; bus write waits
    if (cur_r.awPend && cur_r.wPend && !cur_r.bValid &&
        !((cur_r.fsm == UBD_EVAL) && evWb)) begin
      doWrite = 1'b1;
      cur_nxt.awPend = 1'b0;
      cur_nxt.wPend = 1'b0;
      cur_nxt.bValid = 1'b1;
      cur_nxt.bResp = UBD_AXI_OKAY;
      axiMemWr = isDesc(cur_r.awAddr);
      if (!axiMemWr && !regHit(cur_r.awAddr)) begin
        cur_nxt.bResp = UBD_AXI_SLVERR;
      end
    end

    if (axiMemWr) begin
      // Word at 400h+4*index, bytes status, count, addr low, addr high
      memWe = 1'b1;
      memAddr = cur_r.awAddr[7:2];
      memData = cur_r.wData;
      memStrb = cur_r.wStrb;
    end

    // Register writes, byte lane 0 carries every field
    if (doWrite && cur_r.wStrb[0]) begin
      if (cur_r.awAddr == UBD_CFG_OFS) begin
        cur_nxt.mode = cur_r.wData[UBD_CFG_MODE_LSB +: 2];
        cur_nxt.ptrRst = cur_r.wData[UBD_CFG_PTRRST_BIT];
        cur_nxt.enable = cur_r.wData[UBD_CFG_ENABLE_BIT];
      end else if (cur_r.awAddr == UBD_SFLAG_OFS) begin
        cur_nxt.sFlag = cur_r.wData[7:0] & UBD_SF_WMASK;
      end else if (cur_r.awAddr == UBD_SEN_OFS) begin
        cur_nxt.sEn = cur_r.wData[7:0] & UBD_SF_WMASK | (cur_r.wData[7:0] & 8'h02);
      end else if (cur_r.awAddr == UBD_EFLAG_OFS) begin
        cur_nxt.eFlag = cur_r.wData[7:0];
      end else if (cur_r.awAddr == UBD_EEN_OFS) begin
        cur_nxt.eEn = cur_r.wData[7:0];
      end
    end

    // AXI read, answered one cycle after the address is taken
    if (cur_r.rValid && s_axi_rready) begin
      cur_nxt.rValid = 1'b0;
    end
    if (s_axi_arvalid && !cur_r.rValid) begin
      cur_nxt.rValid = 1'b1;
      cur_nxt.rResp = UBD_AXI_OKAY;
      if (isDesc(s_axi_araddr)) begin
        cur_nxt.rData = descMem[s_axi_araddr[7:2]];
      end else if (regHit(s_axi_araddr)) begin
        cur_nxt.rData = regRead(cur_r, s_axi_araddr, sFlagView);
      end else begin
        cur_nxt.rData = 32'h0000_0000;
        cur_nxt.rResp = UBD_AXI_SLVERR;
      end
    end

    // Engine transaction sequence
    case (cur_r.fsm)
      UBD_IDLE: begin
        if (txnValid) begin
          cur_nxt.cEp = txnEp;
          cur_nxt.cDir = txnDir;
          cur_nxt.cPid = txnPid;
          cur_nxt.cCnt = txnCount;
          cur_nxt.cTog = txnToggle;
          cur_nxt.cSetup = txnSetup;
          cur_nxt.cErr = txnError;
          cur_nxt.odd = usesPingPong(cur_r.mode, txnEp, txnDir) &&
                        cur_r.ptr[{txnEp, txnDir}];
          cur_nxt.idx = descIndex(cur_r.mode, txnEp, txnDir,
                                  usesPingPong(cur_r.mode, txnEp, txnDir) &&
                                  cur_r.ptr[{txnEp, txnDir}]);
          cur_nxt.fsm = UBD_LOOK;
        end
      end
      UBD_LOOK: begin
        cur_nxt.desc = descMem[cur_r.idx];
        cur_nxt.fsm = UBD_EVAL;
      end
      UBD_EVAL: begin
        cur_nxt.rspValid = 1'b1;
        cur_nxt.rspCode = evCode;
        cur_nxt.rspAddr = cur_r.desc[31:16]; // Used unchecked
        cur_nxt.rspIdx = cur_r.idx;
        if (evWb) begin
          memWe = 1'b1;
          memAddr = cur_r.idx;
          memData = {16'h0000, cur_r.cCnt[7:0], wbStatus};
          memStrb = 4'h3;
        end
        if (evTrn) begin
          cur_nxt.xEp = cur_r.cEp;
          cur_nxt.xDir = cur_r.cDir;
          cur_nxt.xOdd = cur_r.odd;
        end
        if (evRelease && usesPingPong(cur_r.mode, cur_r.cEp, cur_r.cDir)) begin
          ptrNext[pBit[4:0]] = !cur_r.ptr[pBit[4:0]];
        end
        cur_nxt.fsm = UBD_IDLE;
      end
      default: begin
        cur_nxt.fsm = UBD_IDLE;
      end
    endcase

    // Pointer reset wins over a toggle
    cur_nxt.enPrev = cur_r.enable;
    if (cur_r.ptrRst || (cur_r.enable && !cur_r.enPrev)) begin
      ptrNext = UBD_PTR_RST;
    end
    cur_nxt.ptr = ptrNext;

    // Hardware sets win over a software clear in the same cycle
    sSet[UBD_SF_SOF] = evtSof;
    sSet[UBD_SF_STALL] = (cur_r.fsm == UBD_EVAL) && evStall;
    sSet[UBD_SF_IDLE] = evtIdle;
    sSet[UBD_SF_TRN] = (cur_r.fsm == UBD_EVAL) && evTrn;
    sSet[UBD_SF_ACTV] = evtActivity;
    sSet[UBD_SF_BUSRST] = evtBusReset;
    cur_nxt.sFlag = cur_nxt.sFlag | sSet;
    cur_nxt.eFlag = cur_nxt.eFlag | errEvents;
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_r <= '0;
      cur_r.fsm <= UBD_IDLE;
      cur_r.sFlag <= UBD_FLAG_RST;
      cur_r.eFlag <= UBD_FLAG_RST;
      cur_r.ptr <= UBD_PTR_RST;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Descriptor RAM write port with byte lanes
  always_ff @(posedge clk) begin
    if (memWe) begin
      for (int i = 0; i < 4; i++) begin
        if (memStrb[i]) begin
          descMem[memAddr][8*i +: 8] <= memData[8*i +: 8];
        end
      end
    end
  end

  // Port drive
  assign s_axi_awready = !cur_r.awPend;
  assign s_axi_wready = !cur_r.wPend;
  assign s_axi_bvalid = cur_r.bValid;
  assign s_axi_bresp = cur_r.bResp;
  assign s_axi_arready = !cur_r.rValid;
  assign s_axi_rvalid = cur_r.rValid;
  assign s_axi_rdata = cur_r.rData;
  assign s_axi_rresp = cur_r.rResp;
  assign txnReady = (cur_r.fsm == UBD_IDLE);
  assign rspValid = cur_r.rspValid;
  assign rspCode = cur_r.rspCode;
  assign rspBufAddr = cur_r.rspAddr;
  assign rspIndex = cur_r.rspIdx;
  // Single request from every enabled status source
  assign usbIrqRequest = |(sFlagView & cur_r.sEn);

endmodule

`default_nettype wire

/* File: dv/ubd_table_monitor.sv */
// Port checker for the descriptor table block, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module ubd_table_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic txnValid,
  input wire logic txnReady,
  input wire logic rspValid,
  input wire logic [1:0] rspCode,
  input wire logic [5:0] rspIndex
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Engine side timing
  a_rsp_latency: assert property (txnValid && txnReady |-> ##3 rspValid)
    else $error("answer late");
  a_busy_window: assert property (txnValid && txnReady |=> !txnReady [*2])
    else $error("taken while busy");
  a_rsp_pulse: assert property (rspValid |=> !rspValid)
    else $error("answer too long");
  a_rsp_ready: assert property (rspValid |-> txnReady)
    else $error("not ready after answer");
  // Reset edge skipped, the held values change there
  a_rsp_held: assert property (!rspValid && !$past(rst) |-> $stable({rspCode, rspIndex}))
    else $error("answer moved without pulse");
  a_code_legal: assert property (rspValid |-> rspCode != 2'h3)
    else $error("bad answer code");
  // Register bus
  a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_turn: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid)
    else $error("write answer late");
  a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
endmodule
bind ubd_table ubd_table_monitor mon_u (.*);
`default_nettype wire

/* File: dv/ubd_engine_model.sv */
// Behavioural serial engine issuing transaction requests to the table.
// Assumes the bench calls send one request at a time.
`timescale 1ns/10ps
`default_nettype none
module ubd_engine_model (
  input wire logic clk,
  output logic txnValid,
  input wire logic txnReady,
  output logic [3:0] txnEp,
  output logic txnDir,
  output logic [3:0] txnPid,
  output logic [9:0] txnCount,
  output logic txnToggle,
  output logic txnSetup,
  output logic txnError,
  input wire logic rspValid,
  input wire logic [1:0] rspCode
);
  initial begin
    txnValid = 1'h0;
    {txnEp, txnDir, txnPid, txnCount, txnToggle, txnSetup, txnError} = '0;
  end
  // fl is {toggle, setup, error}; gap makes the engine slow or prompt
  task automatic send(input logic [3:0] ep, input logic dir, input logic [3:0] pid,
                      input logic [9:0] cnt, input logic [2:0] fl, input int gap,
                      output logic [1:0] code);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    txnValid <= 1'h1;
    {txnEp, txnDir, txnPid} <= {ep, dir, pid};
    txnCount <= cnt;
    {txnToggle, txnSetup, txnError} <= fl;
    do @(posedge clk); while (!txnReady);
    txnValid <= 1'h0;
    // Released lines flip so stale values never look valid
    {txnEp, txnDir, txnPid, txnCount} <= ~{ep, dir, pid, cnt};
    {txnToggle, txnSetup, txnError} <= ~fl;
    do @(posedge clk); while (!rspValid);
    code = rspCode;
  endtask
endmodule
`default_nettype wire

/* File: dv/ubd_table_tb_top.sv */
// Self-checking bench: registers, engine requests, modes and flags.
// Assumes the engine model and the bound checker compile first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin nErrors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module ubd_table_tb_top;
  import ubd_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] s_axi_awaddr = '0;
  logic [11:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [3:0] evt = '0;
  logic [7:0] errEvents = '0;
  wire evtSof = evt[3];
  wire evtIdle = evt[2];
  wire evtActivity = evt[1];
  wire evtBusReset = evt[0];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, rspCode;
  wire [31:0] s_axi_rdata;
  wire txnValid, txnReady, txnDir, txnToggle, txnSetup, txnError, rspValid, usbIrqRequest;
  wire [3:0] txnEp, txnPid;
  wire [9:0] txnCount;
  wire [15:0] rspBufAddr;
  wire [5:0] rspIndex;
  int nErrors = 0;
  int checks = 0;
  logic ptr [32];
  logic [1:0] md, r, code;
  logic [31:0] d, w32;
  logic [11:0] ad;
  logic [3:0] ep;
  logic dir;

  ubd_table dut_u (.*);
  ubd_engine_model eng_u (.*);

  initial forever #2.5 clk = ~clk;

  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw = 1'h1;
    logic w = 1'h1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    // Each channel released on its own ready
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_axi_awready) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    // A late response taker makes the slave hold its answer
    repeat ($urandom_range(2)) @(posedge clk);
    s_axi_bready <= 1'h1;
    do @(posedge clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    repeat ($urandom_range(2)) @(posedge clk);
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Expected descriptor index for the current mode
  function automatic logic [5:0] exp_idx(input logic [3:0] e, input logic dr, input logic odd);
    if (md == UBD_MODE_ALL) return {e, dr, odd};
    if (md == UBD_MODE_EP0OUT) return (e == 4'h0 && !dr) ? {5'h0, odd} : {1'h0, e, dr} + 6'h1;
    return {1'h0, e, dr};
  endfunction

  // Arm a descriptor, run one request, check answer, write-back and flags
  task automatic txn(input logic [3:0] e, input logic dr, input logic [7:0] st,
                     input logic [2:0] fl, input logic [9:0] cnt, input logic [1:0] ec);
    logic [5:0] ix;
    logic [3:0] pid;
    logic [15:0] ba;
    logic [11:0] a;
    logic [31:0] ex;
    logic up;
    ix = exp_idx(e, dr, ptr[{e, dr}]);
    a = UBD_TABLE_BASE + {4'h0, ix, 2'h0};
    pid = 4'($urandom);
    // Buffers start in USB RAM above the mode 1 table
    ba = 16'h0484 + 16'($urandom_range(123));
    wr(a, {ba, 8'hff, st}, r);
    eng_u.send(e, dr, pid, cnt, fl, $urandom_range(2), code);
    `CHK("code", ec, code)
    `CHK("index", ix, rspIndex)
    `CHK("bufaddr", ba, rspBufAddr)
    up = ec == UBD_RSP_ACK && !(st[3] && !fl[1] && fl[2] != st[6]);
    ex = up ? {ba, cnt[7:0], st[5] & ~st[2], st[6], pid, cnt[9:8]} : {ba, 8'hff, st};
    rd(a, d, r);
    `CHK("desc", ex, d)
    rd(UBD_SFLAG_OFS, d, r);
    `CHK("trnflag", up, d[UBD_SF_TRN])
    `CHK("stallflag", ec == UBD_RSP_STALL, d[UBD_SF_STALL])
    wr(UBD_SFLAG_OFS, '0, r);
    if (up) begin
      rd(UBD_XSTAT_OFS, d, r);
      `CHK("xstat", {25'h0, e, dr, ptr[{e, dr}], 1'h0}, d)
    end
    if (up && !ex[7] && (md == UBD_MODE_ALL || (md == UBD_MODE_EP0OUT && e == 4'h0 && !dr)))
      ptr[{e, dr}] = !ptr[{e, dr}];
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Cuts a hang short, far beyond the expected run
  initial begin
    #300000;
    nErrors++;
    test_done();
  end

  initial begin
    void'($urandom(48029));
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      rd(12'(4 * i), d, r);
      `CHK("rstval", 32'h0, d)
    end
    // Holes in the map answer with an error
    wr(12'h01c, '1, r);
    `CHK("wrhole", UBD_AXI_SLVERR, r)
    rd(12'h01c, d, r);
    `CHK("rdhole", {UBD_AXI_SLVERR, 32'h0}, {r, d})
    repeat (8) begin
      ad = UBD_TABLE_BASE + 12'($urandom_range(63) * 4);
      w32 = $urandom;
      wr(ad, w32, r);
      rd(ad, d, r);
      `CHK("descword", w32, d)
    end
    // Each buffering mode; enabling puts pointers on EVEN
    for (int m = 0; m < 3; m++) begin
      md = 2'(m);
      wr(UBD_CFG_OFS, '0, r);
      wr(UBD_CFG_OFS, {28'h0, 2'h2, md}, r);
      ptr = '{default: 1'h0};
      for (int k = 0; k < 8; k++) begin
        ep = k < 2 ? 4'h0 : k == 2 ? 4'hf : 4'($urandom);
        dir = k < 2 ? 1'h0 : k == 2 ? 1'h1 : 1'($urandom);
        repeat (2) txn(ep, dir, {1'h1, 1'($urandom), 6'h0}, 3'h0, 10'($urandom_range(255)),
                       UBD_RSP_ACK);
      end
    end
    // Pointer reset bit forces EVEN again
    txn(4'h3, 1'h1, 8'h80, 3'h0, 10'h5, UBD_RSP_ACK);
    wr(UBD_CFG_OFS, 32'he, r);
    wr(UBD_CFG_OFS, 32'ha, r);
    ptr = '{default: 1'h0};
    txn(4'h3, 1'h1, 8'h80, 3'h0, 10'h5, UBD_RSP_ACK);
    // Refusals and status-byte options
    txn(4'h5, 1'h0, 8'h00, 3'h0, 10'h4, UBD_RSP_NAK);
    txn(4'h5, 1'h1, 8'h84, 3'h0, 10'h4, UBD_RSP_STALL);
    txn(4'h5, 1'h1, 8'h84, 3'h2, 10'h8, UBD_RSP_ACK);
    txn(4'h6, 1'h0, 8'h80, 3'h1, 10'h4, UBD_RSP_NAK);
    txn(4'h6, 1'h0, 8'h80, 3'h0, 10'h12c, UBD_RSP_NAK);
    txn(4'h7, 1'h0, 8'h88, 3'h4, 10'h4, UBD_RSP_ACK);
    txn(4'h7, 1'h0, 8'hc0, 3'h0, 10'h4, UBD_RSP_ACK);
    txn(4'h8, 1'h1, 8'ha0, 3'h0, 10'h3ff, UBD_RSP_ACK);
    // Only enabled error flags reach the summary bit
    wr(UBD_SEN_OFS, 32'h7f, r);
    wr(UBD_EEN_OFS, 32'h0f, r);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      errEvents <= i ? 8'h02 : 8'h20;
      @(posedge clk);
      errEvents <= '0;
      rd(UBD_EFLAG_OFS, d, r);
      `CHK("errflag", i ? 8'h22 : 8'h20, d[7:0])
      rd(UBD_SFLAG_OFS, d, r);
      `CHK("summary", i ? 8'h02 : 8'h00, d[7:0])
      `CHK("irqerr", 1'(i), usbIrqRequest)
    end
    wr(UBD_SEN_OFS, 32'h7d, r);
    `CHK("irqmask", 1'h0, usbIrqRequest)
    wr(UBD_EFLAG_OFS, '0, r);
    wr(UBD_SEN_OFS, 32'h7f, r);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      evt <= 4'(1 << i);
      @(posedge clk);
      evt <= '0;
      rd(UBD_SFLAG_OFS, d, r);
      `CHK("evtflag", 8'(1 << (2 * i)), d[7:0])
      `CHK("irqevt", 1'h1, usbIrqRequest)
      wr(UBD_SFLAG_OFS, '0, r);
    end
    `CHK("irqoff", 1'h0, usbIrqRequest)
    test_done();
  end
endmodule
`default_nettype wire
